/* File: common/pse_event_pkg.sv */
// package: command codes, field layout, timing and carrier types of the event bank
package pse_event_pkg;

  localparam int PORTS    = 4;
  localparam int RESULT_W = 4;

  // command codes of the eight register views
  localparam logic [7:0] CMD_POWER_VIEW   = 8'h02;
  localparam logic [7:0] CMD_POWER_CLEAR  = 8'h03;
  localparam logic [7:0] CMD_DETECT_VIEW  = 8'h04;
  localparam logic [7:0] CMD_DETECT_CLEAR = 8'h05;
  localparam logic [7:0] CMD_FAULT_VIEW   = 8'h06;
  localparam logic [7:0] CMD_FAULT_CLEAR  = 8'h07;
  localparam logic [7:0] CMD_START_VIEW   = 8'h08;
  localparam logic [7:0] CMD_START_CLEAR  = 8'h09;

  // nibble positions inside each event register
  localparam int HIGH_NIBBLE_LSB = 4;
  localparam int LOW_NIBBLE_LSB  = 0;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE   = 8'h00;
  localparam logic [7:0] ALL_FLAGS   = 8'hff;

  // summary bit positions, shared with the interrupt mask layout
  localparam int SUM_POWER_ENABLE = 0;
  localparam int SUM_POWER_GOOD   = 1;
  localparam int SUM_DISCONNECT   = 2;
  localparam int SUM_DETECT       = 3;
  localparam int SUM_CLASS        = 4;
  localparam int SUM_OVERLOAD     = 5;
  localparam int SUM_START        = 6;
  localparam int SUM_W            = 7;

  // timing
  localparam int CLOCK_MHZ             = 20;
  localparam int OVERLOAD_TIME_US      = 60000;
  localparam int CURRENT_LIMIT_TIME_US = 60000;
  localparam int OVERLOAD_CYCLES       = OVERLOAD_TIME_US * CLOCK_MHZ;
  localparam int LIMIT_CYCLES          = CURRENT_LIMIT_TIME_US * CLOCK_MHZ;

  // per-port status and event strobes from the port engines
  typedef struct packed {
    logic [PORTS-1:0]          powerGood;
    logic [PORTS-1:0]          powerEnable;
    logic [PORTS-1:0]          detectDone;
    logic [PORTS-1:0]          classDone;
    logic [PORTS*RESULT_W-1:0] detectResult;
    logic [PORTS*RESULT_W-1:0] classResult;
    logic [PORTS-1:0]          disconnect;
    logic [PORTS-1:0]          currentLimitFault;
    logic [PORTS-1:0]          startFault;
    logic [PORTS-1:0]          overloadActive;
  } engine_events_t;

  // host command request and answer
  typedef struct packed {
    logic       read;
    logic [7:0] code;
  } cmd_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [7:0] data;
  } cmd_rsp_t;

  // sticky update: a new event wins over a clear in the same cycle
  function automatic logic [7:0] applyFlags(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic [7:0] clr);
    return (cur & ~clr) | set;
  endfunction

  // widen a per-port vector to both nibbles of an event register
  function automatic logic [7:0] bothNibbles(input logic [PORTS-1:0] p);
    return {p, p};
  endfunction

endpackage

/* File: hw/pse_change_detect.sv */
// per-port event generator: any completed cycle, or only a changed result
`timescale 1ns/1ps
`default_nettype none

module pse_change_detect #(
  parameter int PORTS = 4,
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // sampling
  input  wire logic [PORTS-1:0]       sample,
  input  wire logic [PORTS*WIDTH-1:0] value,
  input  wire logic                   changeMode,
  // result
  output logic      [PORTS-1:0]       eventOut
);

  generate
    if (PORTS < 1 || WIDTH < 1)
    begin : g_check
      $error("pse_change_detect: PORTS and WIDTH must be positive");
    end
  endgenerate

  typedef struct packed {
    logic [PORTS*WIDTH-1:0] last;
    logic [PORTS-1:0]       evt;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.evt = '0;
    for (int p = 0; p < PORTS; p++)
    begin
      if (sample[p])
      begin
        state_nxt.evt[p] = !changeMode ||
          (value[p*WIDTH +: WIDTH] != state_r.last[p*WIDTH +: WIDTH]);
        state_nxt.last[p*WIDTH +: WIDTH] = value[p*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign eventOut = state_r.evt;

endmodule // pse_change_detect

`default_nettype wire

/* File: hw/pse_overload_timer.sv */
// one port's overload fault timer with optional cutoff
`timescale 1ns/1ps
`default_nettype none

module pse_overload_timer #(
  parameter int OVLD_CYCLES = 1200000,
  parameter int HALF_CYCLES = 600000,
  parameter int CW          = $clog2(OVLD_CYCLES + HALF_CYCLES + 1)
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // control
  input  wire logic overloadActive,
  input  wire logic cutoffEnable,
  input  wire logic counterClear,
  // result
  output logic      faultPulse,
  output logic      shutdownPulse
);

  generate
    if (OVLD_CYCLES < 1 || HALF_CYCLES < 1)
    begin : g_check
      $error("pse_overload_timer: timeouts must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] count;
    logic          fired;
    logic          fault;
    logic          shut;
  } state_t;

  state_t        state_r;
  state_t        state_nxt;
  logic [CW-1:0] limit;

  always_comb
  begin
    limit = cutoffEnable ? CW'(OVLD_CYCLES - 1) : CW'(HALF_CYCLES - 1);
    state_nxt = state_r;
    state_nxt.fault = 1'b0;
    state_nxt.shut  = 1'b0;
    if (counterClear && !cutoffEnable)
    begin
      // restart so a still-present overload can flag again
      state_nxt.count = '0;
      state_nxt.fired = 1'b0;
    end
    else if (!overloadActive)
    begin
      state_nxt.count = '0;
      state_nxt.fired = 1'b0;
    end
    else if (!state_r.fired)
    begin
      if (state_r.count >= limit)
      begin
        state_nxt.fired = 1'b1;
        state_nxt.fault = 1'b1;
        state_nxt.shut  = cutoffEnable;
      end
      else
        state_nxt.count = state_r.count + CW'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign faultPulse    = state_r.fault;
  assign shutdownPulse = state_r.shut;

endmodule // pse_overload_timer

`default_nettype wire

/* File: hw/pse_port_event_registers.sv */
// event flag registers of one four-port bank with plain and clearing reads
//
// Operation
// - power events read at 02h, and at 03h which then clears them all
// - detection events read at 04h, and at 05h which then clears them
// - fault events read at 06h, and at 07h which then clears them
// - start/limit events read at 08h, and at 09h which clears them
// - a clearing read that empties the cause releases the interrupt line
// - flags are active high, one per port, port 1 lowest in each nibble
// - power event high nibble sets on a power-good change
// - power event low nibble sets on a power-enable change
// - class flags: any class cycle, or only class change when mode set
// - detect flags: any detect cycle, or only result change when mode set
// - detection, fault and start flags of a port clear at port turn-off
// - fault high nibble is disconnect, low nibble is overload timeout
// - without cutoff the port stays on; flag times out at half limit
// - without cutoff a clearing fault read also restarts overload counter
// - with cutoff the normal overload timer is used, nothing restarts
// - any set flag shows in its summary bit
// - each summary bit is the OR of its flags over the four ports
// - summary drives interrupt only if masked in and globally enabled
`timescale 1ns/1ps
`default_nettype none

module pse_port_event_registers #(
  parameter int PORTS           = pse_event_pkg::PORTS,
  parameter int RESULT_W        = pse_event_pkg::RESULT_W,
  parameter int OVERLOAD_CYCLES = pse_event_pkg::OVERLOAD_CYCLES,
  parameter int LIMIT_CYCLES    = pse_event_pkg::LIMIT_CYCLES
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // host command port
  input  wire pse_event_pkg::cmd_req_t       cmdReq,
  output pse_event_pkg::cmd_rsp_t            cmdRsp,
  // port engine status and strobes
  input  wire pse_event_pkg::engine_events_t engine,
  // configuration
  input  wire logic                          classChangeMode,
  input  wire logic                          detectChangeMode,
  input  wire logic [PORTS-1:0]              overloadCutoff,
  input  wire logic [7:0]                    interruptMask,
  input  wire logic                          irqGlobalEnable,
  // summary and interrupt
  output logic [pse_event_pkg::SUM_W-1:0]    summary,
  output logic                               eventInt_n,
  output logic [PORTS-1:0]                   overloadShutdown
);

  // the nibble layout and the engine struct fix the bank at four ports
  generate
    if (PORTS != pse_event_pkg::PORTS ||
        RESULT_W != pse_event_pkg::RESULT_W)
    begin : g_check_ports
      $error("pse_port_event_registers: bank layout is four ports");
    end
    if (OVERLOAD_CYCLES < 1 || LIMIT_CYCLES < 2)
    begin : g_check_times
      $error("pse_port_event_registers: timeouts too short");
    end
  endgenerate

  // half of the current-limit time, rounded up as a least time
  localparam int HALF_LIMIT_CYCLES = (LIMIT_CYCLES + 1) / 2;

  typedef struct packed {
    logic [7:0]                     powerEvt;
    logic [7:0]                     detectEvt;
    logic [7:0]                     faultEvt;
    logic [7:0]                     startEvt;
    logic [PORTS-1:0]               prevEnable;
    logic [7:0]                     readData;
    logic                           readValid;
    logic                           readHit;
    logic [pse_event_pkg::SUM_W-1:0] summary;
    logic                           intLine_n;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // event sources, registered inside their own modules, and the combinational overload counter-clear decode
  logic [PORTS-1:0] powerGoodChange;
  logic [PORTS-1:0] powerEnableChange;
  logic [PORTS-1:0] classEvent;
  logic [PORTS-1:0] detectEvent;
  logic [PORTS-1:0] overloadFault;
  logic [PORTS-1:0] overloadCut;
  logic [PORTS-1:0] overloadCounterClear;

  // decoded command
  logic       clearPower;
  logic       clearDetect;
  logic       clearFault;
  logic       clearStart;
  logic [7:0] viewData;
  logic       viewHit;

  // power good and enable are levels: sample every cycle, flag on change
  pse_change_detect #(
    .PORTS (PORTS),
    .WIDTH (1)
  ) u_power_good (
    .clock      (clock),
    .reset      (reset),
    .sample     ({PORTS{1'b1}}),
    .value      (engine.powerGood),
    .changeMode (1'b1),
    .eventOut   (powerGoodChange)
  );

  pse_change_detect #(
    .PORTS (PORTS),
    .WIDTH (1)
  ) u_power_enable (
    .clock      (clock),
    .reset      (reset),
    .sample     ({PORTS{1'b1}}),
    .value      (engine.powerEnable),
    .changeMode (1'b1),
    .eventOut   (powerEnableChange)
  );

  // class and detection results are taken at the end of each cycle
  pse_change_detect #(
    .PORTS (PORTS),
    .WIDTH (RESULT_W)
  ) u_class (
    .clock      (clock),
    .reset      (reset),
    .sample     (engine.classDone),
    .value      (engine.classResult),
    .changeMode (classChangeMode),
    .eventOut   (classEvent)
  );

  pse_change_detect #(
    .PORTS (PORTS),
    .WIDTH (RESULT_W)
  ) u_detect (
    .clock      (clock),
    .reset      (reset),
    .sample     (engine.detectDone),
    .value      (engine.detectResult),
    .changeMode (detectChangeMode),
    .eventOut   (detectEvent)
  );

  // one overload timer per port
  for (genvar p = 0; p < PORTS; p++)
  begin : g_overload
    pse_overload_timer #(
      .OVLD_CYCLES (OVERLOAD_CYCLES),
      .HALF_CYCLES (HALF_LIMIT_CYCLES)
    ) u_timer (
      .clock          (clock),
      .reset          (reset),
      .overloadActive (engine.overloadActive[p]),
      .cutoffEnable   (overloadCutoff[p]),
      .counterClear   (overloadCounterClear[p]),
      .faultPulse     (overloadFault[p]),
      .shutdownPulse  (overloadCut[p])
    );
  end

  // command decode; an unmapped code answers zero with the hit bit low
  always_comb
  begin
    clearPower  = 1'b0;
    clearDetect = 1'b0;
    clearFault  = 1'b0;
    clearStart  = 1'b0;
    viewHit     = 1'b1;
    viewData    = pse_event_pkg::READ_IDLE;
    case (cmdReq.code)
      pse_event_pkg::CMD_POWER_VIEW:
        viewData = state_r.powerEvt;
      pse_event_pkg::CMD_POWER_CLEAR:
      begin
        viewData   = state_r.powerEvt;
        clearPower = cmdReq.read;
      end
      pse_event_pkg::CMD_DETECT_VIEW:
        viewData = state_r.detectEvt;
      pse_event_pkg::CMD_DETECT_CLEAR:
      begin
        viewData    = state_r.detectEvt;
        clearDetect = cmdReq.read;
      end
      pse_event_pkg::CMD_FAULT_VIEW:
        viewData = state_r.faultEvt;
      pse_event_pkg::CMD_FAULT_CLEAR:
      begin
        viewData   = state_r.faultEvt;
        clearFault = cmdReq.read;
      end
      pse_event_pkg::CMD_START_VIEW:
        viewData = state_r.startEvt;
      pse_event_pkg::CMD_START_CLEAR:
      begin
        viewData   = state_r.startEvt;
        clearStart = cmdReq.read;
      end
      default:
        viewHit = 1'b0;
    endcase
  end

  // only ports without cutoff have their counter restarted by the read
  assign overloadCounterClear =
    {PORTS{clearFault}} & ~overloadCutoff;

  always_comb
  begin
    logic [PORTS-1:0] portOff;
    logic [7:0]       offClear;
    logic [7:0]       anyClear;
    logic [pse_event_pkg::SUM_W-1:0] sumNxt;
    portOff  = '0;
    offClear = '0;
    anyClear = '0;
    sumNxt   = '0;
    state_nxt = state_r;

    // turn-off is the falling edge of the port's power enable
    portOff  = state_r.prevEnable & ~engine.powerEnable;
    offClear = pse_event_pkg::bothNibbles(portOff);
    state_nxt.prevEnable = engine.powerEnable;

    // the value returned is the one held before any clear takes effect
    state_nxt.readValid = cmdReq.read;
    state_nxt.readHit   = cmdReq.read && viewHit;
    state_nxt.readData  = cmdReq.read ? viewData : pse_event_pkg::READ_IDLE;

    // power events are not cleared by turn-off: the enable change itself
    // is one of the flags
    anyClear = clearPower ? pse_event_pkg::ALL_FLAGS : 8'h00;
    state_nxt.powerEvt = pse_event_pkg::applyFlags(
      state_r.powerEvt,
      {powerGoodChange, powerEnableChange},
      anyClear);

    anyClear = (clearDetect ? pse_event_pkg::ALL_FLAGS : 8'h00) | offClear;
    state_nxt.detectEvt = pse_event_pkg::applyFlags(
      state_r.detectEvt,
      {classEvent, detectEvent},
      anyClear);

    // a disconnect usually ends with turn-off; the set still wins
    anyClear = (clearFault ? pse_event_pkg::ALL_FLAGS : 8'h00) | offClear;
    state_nxt.faultEvt = pse_event_pkg::applyFlags(
      state_r.faultEvt,
      {engine.disconnect, overloadFault},
      anyClear);

    // the host relies on the enable-change flag to classify start faults
    anyClear = (clearStart ? pse_event_pkg::ALL_FLAGS : 8'h00) | offClear;
    state_nxt.startEvt = pse_event_pkg::applyFlags(
      state_r.startEvt,
      {engine.currentLimitFault, engine.startFault},
      anyClear);

    // summary follows the flags whatever the mask says
    sumNxt[pse_event_pkg::SUM_POWER_ENABLE] =
      |state_nxt.powerEvt[pse_event_pkg::LOW_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_POWER_GOOD] =
      |state_nxt.powerEvt[pse_event_pkg::HIGH_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_DISCONNECT] =
      |state_nxt.faultEvt[pse_event_pkg::HIGH_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_DETECT] =
      |state_nxt.detectEvt[pse_event_pkg::LOW_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_CLASS] =
      |state_nxt.detectEvt[pse_event_pkg::HIGH_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_OVERLOAD] =
      |state_nxt.faultEvt[pse_event_pkg::LOW_NIBBLE_LSB +: PORTS] |
      |state_nxt.startEvt[pse_event_pkg::HIGH_NIBBLE_LSB +: PORTS];
    sumNxt[pse_event_pkg::SUM_START] =
      |state_nxt.startEvt[pse_event_pkg::LOW_NIBBLE_LSB +: PORTS];
    state_nxt.summary = sumNxt;

    // the line drops while any enabled summary bit is set, so emptying
    // the register behind it releases the line on the same edge
    state_nxt.intLine_n = !(irqGlobalEnable &&
      |(sumNxt & interruptMask[pse_event_pkg::SUM_W-1:0]));
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r            <= '0;
      state_r.powerEvt   <= pse_event_pkg::EVENT_RESET;
      state_r.detectEvt  <= pse_event_pkg::EVENT_RESET;
      state_r.faultEvt   <= pse_event_pkg::EVENT_RESET;
      state_r.startEvt   <= pse_event_pkg::EVENT_RESET;
      state_r.intLine_n  <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  assign cmdRsp.valid     = state_r.readValid;
  assign cmdRsp.hit       = state_r.readHit;
  assign cmdRsp.data      = state_r.readData;
  assign summary          = state_r.summary;
  assign eventInt_n       = state_r.intLine_n;
  assign overloadShutdown = overloadCut;

endmodule // pse_port_event_registers

`default_nettype wire

/* File: verif/pse_event_checker.sv */
// concurrent checks on the ports of the event register bank
`timescale 1ns/1ps
`default_nettype none

module pse_event_checker (
  // clock and reset
  input wire logic                             clock,
  input wire logic                             reset,
  // host command port
  input wire pse_event_pkg::cmd_req_t          cmdReq,
  input wire pse_event_pkg::cmd_rsp_t          cmdRsp,
  // engine and configuration
  input wire pse_event_pkg::engine_events_t    engine,
  input wire logic [pse_event_pkg::PORTS-1:0]  overloadCutoff,
  input wire logic [7:0]                       interruptMask,
  input wire logic                             irqGlobalEnable,
  // outputs under watch
  input wire logic [pse_event_pkg::SUM_W-1:0]  summary,
  input wire logic                             eventInt_n,
  input wire logic [pse_event_pkg::PORTS-1:0]  overloadShutdown
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence readOf(logic [7:0] c);
    cmdReq.read && cmdReq.code == c;
  endsequence

  sequence answered;
    cmdRsp.valid && cmdRsp.hit == ($past(cmdReq.code) inside {[2:9]});
  endsequence

  AST_RSP: assert property (cmdReq.read |=> answered)
    else $error("read not answered one cycle later");
  AST_IDLE: assert property (!cmdReq.read |=> !cmdRsp.valid &&
    cmdRsp.data == 8'h00) else $error("answer without a read");
  AST_DISC: assert property (|engine.disconnect |=>
    summary[pse_event_pkg::SUM_DISCONNECT]) else $error("disconnect lost");
  AST_LIM: assert property (|engine.currentLimitFault |=>
    summary[pse_event_pkg::SUM_OVERLOAD]) else $error("limit fault lost");
  AST_START: assert property (|engine.startFault |=>
    summary[pse_event_pkg::SUM_START]) else $error("start fault lost");
  AST_INT: assert property (##1 eventInt_n ==
    !($past(irqGlobalEnable) && |(summary & $past(interruptMask[6:0]))))
    else $error("interrupt level");
  AST_STICKY: assert property (summary[2] && !cmdReq.read &&
    $stable(engine.powerEnable) |=> summary[2]) else $error("flag dropped");
  AST_CLEAR: assert property (readOf(8'h07) ##0
    engine.disconnect == 4'h0 |=> !summary[2])
    else $error("clearing read left fault flags");
  AST_SHUT: assert property (|overloadShutdown |->
    (overloadShutdown & ~$past(overloadCutoff)) == 4'h0)
    else $error("shutdown without cutoff");
  AST_RESET: assert property (disable iff (1'b0) reset |=>
    summary == '0 && eventInt_n && !cmdRsp.valid) else $error("reset state");
endmodule // pse_event_checker

bind pse_port_event_registers pse_event_checker i_pse_event_checker (
  .clock            (clock),
  .reset            (reset),
  .cmdReq           (cmdReq),
  .cmdRsp           (cmdRsp),
  .engine           (engine),
  .overloadCutoff   (overloadCutoff),
  .interruptMask    (interruptMask),
  .irqGlobalEnable  (irqGlobalEnable),
  .summary          (summary),
  .eventInt_n       (eventInt_n),
  .overloadShutdown (overloadShutdown)
);

`default_nettype wire

/* File: verif/pse_host_model.sv */
// host side command master standing in for the serial engine
`timescale 1ns/1ps
`default_nettype none

module pse_host_model (
  // clock
  input  wire logic                    clock,
  // command port
  output var pse_event_pkg::cmd_req_t  cmdReq,
  input  wire pse_event_pkg::cmd_rsp_t cmdRsp
);
  initial cmdReq = '0;

  // one strobe per read; code is scrambled after so no stale value lingers
  // the answer stands one cycle only, so it is taken just after the strobe
  task automatic rd(input logic [7:0] code, output logic [7:0] data,
                    output logic hit);
    @(posedge clock);
    cmdReq <= '{read: 1'b1, code: code};
    @(posedge clock);
    cmdReq <= '{read: 1'b0, code: ~code};
    #1;
    data = cmdRsp.data;
    hit = cmdRsp.hit & cmdRsp.valid;
    @(posedge clock);
    #1;
  endtask

  // a start fault counts as inrush when the port's enable-change flag is up
  function automatic logic inrush(input logic [7:0] power, input int p);
    return power[p];
  endfunction
endmodule // pse_host_model

`default_nettype wire

/* File: verif/pse_port_event_registers_test.sv */
// self-checking bench of the event register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module pse_port_event_registers_test;
  logic                          clock = 1'b0;
  logic                          reset = 1'b1;
  pse_event_pkg::cmd_req_t       cmdReq;
  pse_event_pkg::cmd_rsp_t       cmdRsp;
  pse_event_pkg::engine_events_t eng = '0;
  logic                          classChangeMode = 1'b0;
  logic                          detectChangeMode = 1'b0;
  logic [3:0]                    overloadCutoff = 4'h0;
  logic [7:0]                    interruptMask = 8'h04;
  logic                          irqGlobalEnable = 1'b1;
  logic [6:0]                    summary;
  logic                          eventInt_n;
  logic [3:0]                    overloadShutdown;
  logic [3:0]                    sawShut = 4'h0;
  int                            miscompares = 0;
  int                            check_count = 0;
  int                            cycles = 0;

  always #25 clock = ~clock;
  always @(posedge clock) sawShut <= sawShut | overloadShutdown;

  pse_port_event_registers #(
    .OVERLOAD_CYCLES (40),
    .LIMIT_CYCLES    (40)
  ) i_pse_port_event_registers (
    .clock            (clock),
    .reset            (reset),
    .cmdReq           (cmdReq),
    .cmdRsp           (cmdRsp),
    .engine           (eng),
    .classChangeMode  (classChangeMode),
    .detectChangeMode (detectChangeMode),
    .overloadCutoff   (overloadCutoff),
    .interruptMask    (interruptMask),
    .irqGlobalEnable  (irqGlobalEnable),
    .summary          (summary),
    .eventInt_n       (eventInt_n),
    .overloadShutdown (overloadShutdown)
  );

  pse_host_model i_pse_host_model (
    .clock  (clock),
    .cmdReq (cmdReq),
    .cmdRsp (cmdRsp)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    logic       h;
    i_pse_host_model.rd(code, d, h);
    `CHK(h, 1'b1)
    `CHK(d, exp)
  endtask

  // one-cycle engine pulses, then enough idle edges for the detectors
  task automatic strobe(input logic [3:0] dt, cl, ds, lm, st);
    @(posedge clock);
    eng.detectDone <= dt;
    eng.classDone <= cl;
    eng.disconnect <= ds;
    eng.currentLimitFault <= lm;
    eng.startFault <= st;
    @(posedge clock);
    eng.detectDone <= 4'h0;
    eng.classDone <= 4'h0;
    eng.disconnect <= 4'h0;
    eng.currentLimitFault <= 4'h0;
    eng.startFault <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic       h;
    for (int c = 2; c < 10; c++)
      rdchk(8'(c), 8'h00);
    i_pse_host_model.rd(8'h0a, d, h);
    `CHK({h, d}, 9'h000)
    `CHK(eventInt_n, 1'b1)
    $display("t_reset done");
  endtask

  task automatic t_power();
    @(posedge clock);
    eng.powerEnable <= 4'h1;
    eng.powerGood <= 4'h4;
    repeat (3) @(posedge clock);
    rdchk(8'h02, 8'h41);
    rdchk(8'h02, 8'h41);
    rdchk(8'h03, 8'h41);
    rdchk(8'h02, 8'h00);
    `CHK(summary[1:0], 2'b00)
    $display("t_power done");
  endtask

  task automatic t_detect();
    @(posedge clock);
    eng.detectResult[7:4] <= 4'h5;
    eng.classResult[15:12] <= 4'h3;
    strobe(4'h2, 4'h8, 4'h0, 4'h0, 4'h0);
    rdchk(8'h05, 8'h82);
    rdchk(8'h04, 8'h00);
    @(posedge clock);
    detectChangeMode <= 1'b1;
    classChangeMode <= 1'b1;
    strobe(4'h2, 4'h8, 4'h0, 4'h0, 4'h0);
    rdchk(8'h04, 8'h00);
    @(posedge clock);
    eng.detectResult[7:4] <= 4'h6;
    strobe(4'h2, 4'h8, 4'h0, 4'h0, 4'h0);
    rdchk(8'h05, 8'h02);
    $display("t_detect done");
  endtask

  task automatic t_fault();
    strobe(4'h0, 4'h0, 4'h2, 4'h0, 4'h0);
    `CHK(summary[2], 1'b1)
    `CHK(eventInt_n, 1'b0)
    @(posedge clock);
    irqGlobalEnable <= 1'b0;
    @(posedge clock);
    irqGlobalEnable <= 1'b1;
    #1;
    `CHK(eventInt_n, 1'b1)
    `CHK(summary[2], 1'b1)
    rdchk(8'h06, 8'h20);
    `CHK(eventInt_n, 1'b0)
    rdchk(8'h07, 8'h20);
    `CHK(eventInt_n, 1'b1)
    strobe(4'h0, 4'h0, 4'h0, 4'h4, 4'h1);
    `CHK(summary[6:5], 2'b11)
    `CHK(eventInt_n, 1'b1)
    rdchk(8'h09, 8'h41);
    rdchk(8'h08, 8'h00);
    $display("t_fault done");
  endtask

  // port 2 without cutoff restarts on a clearing read, port 3 fires once
  task automatic t_overload();
    @(posedge clock);
    overloadCutoff <= 4'h4;
    eng.overloadActive <= 4'h6;
    repeat (10) @(posedge clock);
    rdchk(8'h06, 8'h00);
    repeat (14) @(posedge clock);
    rdchk(8'h07, 8'h02);
    rdchk(8'h06, 8'h00);
    repeat (20) @(posedge clock);
    rdchk(8'h07, 8'h06);
    repeat (10) @(posedge clock);
    rdchk(8'h06, 8'h00);
    repeat (15) @(posedge clock);
    rdchk(8'h06, 8'h02);
    `CHK(sawShut, 4'h4)
    @(posedge clock);
    eng.overloadActive <= 4'h0;
    $display("t_overload done");
  endtask

  task automatic t_turnoff();
    logic [7:0] d;
    logic       h;
    rdchk(8'h07, 8'h02);
    strobe(4'h0, 4'h0, 4'h1, 4'h0, 4'h1);
    rdchk(8'h06, 8'h10);
    @(posedge clock);
    eng.powerEnable <= 4'h0;
    repeat (3) @(posedge clock);
    rdchk(8'h06, 8'h00);
    rdchk(8'h08, 8'h00);
    i_pse_host_model.rd(8'h03, d, h);
    `CHK(d, 8'h01)
    `CHK(i_pse_host_model.inrush(d, 0), 1'b1)
    $display("t_turnoff done");
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_power();
    t_detect();
    t_fault();
    t_overload();
    t_turnoff();
    end_of_test();
  end
endmodule // pse_port_event_registers_test

`default_nettype wire
